//--- logic/tpc_pkg.sv
// package of register map, field layout and timing constants for the timer counter core
package tpc_pkg;
  // register byte addresses (one aligned word each)
  localparam logic [7:0] TPC_OFS_SC      = 8'h00;  // timer_status_control
  localparam logic [7:0] TPC_OFS_CNTH    = 8'h04;  // counter_high_byte
  localparam logic [7:0] TPC_OFS_CNTL    = 8'h08;  // counter_low_byte
  localparam logic [7:0] TPC_OFS_MODH    = 8'h0C;  // modulo_value high byte
  localparam logic [7:0] TPC_OFS_MODL    = 8'h10;  // modulo_value low byte
  localparam logic [7:0] TPC_OFS_CTRL    = 8'h14;  // shared pin ownership control
  // status/control field positions
  localparam int TPC_SC_OVF   = 7;  // overflow_flag
  localparam int TPC_SC_OVIE  = 6;  // overflow_irq_enable
  localparam int TPC_SC_CENTER_ALIGNED_PWM  = 5;  // center_pwm_select
  localparam int TPC_SC_CLKHI = 4;  // clock_source_select msb
  localparam int TPC_SC_CLKLO = 3;  // clock_source_select lsb
  localparam int TPC_SC_PSHI  = 2;  // prescale_select msb
  // reset values
  localparam logic [7:0]  TPC_SC_RESET  = 8'h00;
  localparam logic [15:0] TPC_MOD_RESET = 16'h0000;
  localparam logic [15:0] TPC_CNT_RESET = 16'h0000;
  // clock source codes
  localparam logic [1:0] TPC_CLK_OFF = 2'h0;
  localparam logic [1:0] TPC_CLK_BUS = 2'h1;
  localparam logic [1:0] TPC_CLK_FIX = 2'h2;
  localparam logic [1:0] TPC_CLK_EXT = 2'h3;
  // synchronizer depth
  localparam int TPC_SYNC_STAGES = 2;
endpackage

//--- logic/tpc_sync_edge.sv
// two-flop synchronizer with rising edge pulse for slow clock inputs
`timescale 1ns/1ps
module tpc_sync_edge
  import tpc_pkg::*;
(
  input  wire logic hclk,     // bus clock
  input  wire logic hresetn,  // async reset, active low
  input  wire logic async_in, // asynchronous clock level
  output logic      rise_pls  // one-cycle pulse per rising edge
);
  // first, second and edge-history flops
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tpc_sync_s;
  tpc_sync_s st_reg;   // registered state
  tpc_sync_s st_next;  // next state

  // shift chain; only s2 looks at s1
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // edge seen on synchronized levels only
  assign rise_pls = st_reg.s2 & ~st_reg.s3;
endmodule // tpc_sync_edge

//--- logic/tpc_prescaler.sv
// power-of-two prescaler producing single-cycle count enables
`timescale 1ns/1ps
module tpc_prescaler
  import tpc_pkg::*;
#(
  parameter int PS_W = 3  // width of prescale code
) (
  input  wire logic            hclk,    // bus clock
  input  wire logic            hresetn, // async reset, active low
  input  wire logic            tick,    // selected source tick
  input  wire logic            freeze,  // hold in debug
  input  wire logic [PS_W-1:0] ps_sel,  // prescale code
  output logic                 cnt_en   // one-cycle count enable
);
  localparam int DW = (1 << PS_W) - 1;  // divider width, 7 for 128
  typedef struct packed {
    logic [DW-1:0] div;
  } tpc_ps_s;
  tpc_ps_s st_reg;   // registered divider
  tpc_ps_s st_next;  // next divider
  logic [DW-1:0] mask;  // divisor minus one

  // divider advances on source ticks, wraps at the selected divisor
  always_comb begin
    st_next = st_reg;
    mask    = DW'((1 << ps_sel) - 1);
    cnt_en  = 1'b0;
    if (tick && !freeze) begin
      if ((st_reg.div & mask) == mask) begin
        st_next.div = '0;
        cnt_en      = 1'b1;
      end else begin
        st_next.div = st_reg.div + 1'b1;
      end
    end
  end

  // divider register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // tpc_prescaler

//--- logic/tpc_core.sv
// timer/pwm counter core with clock select, prescaler, overflow flag and ahb-lite registers
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module tpc_core
  import tpc_pkg::*;
(
  input  wire logic        hclk,          // bus clock, 25 MHz
  input  wire logic        hresetn,       // async reset, active low
  input  wire logic        hsel,          // slave select
  input  wire logic [7:0]  haddr,         // byte address
  input  wire logic [1:0]  htrans,        // transfer type
  input  wire logic        hwrite,        // write strobe
  input  wire logic [2:0]  hsize,         // transfer size
  input  wire logic [31:0] hwdata,        // write data
  input  wire logic        hready,        // bus ready in
  output logic [31:0]      hrdata,        // read data
  output logic             hreadyout,     // always ready
  output logic             hresp,         // always okay
  input  wire logic        fixed_clk,     // fixed_system_clock level
  input  wire logic        ext_clk_pin,   // external_timer_clock_pin level
  input  wire logic        debug_active,  // background debug mode
  output logic [15:0]      count_value,   // counter to channels
  output logic             center_pwm,    // center_aligned_pwm to channels
  output logic             count_tick,    // counter advanced this cycle
  output logic             overflow_pls,  // overflow event pulse
  output logic             overflow_irq,  // overflow interrupt request
  output logic             pin_timer_own  // timer owns the shared pin
);
  // core state
  typedef struct packed {
    logic        ovf;        // overflow_flag
    logic        ovie;       // overflow_irq_enable
    logic        center_aligned_pwm;       // center_pwm_select
    logic [1:0]  clks;       // clock_source_select
    logic [2:0]  ps;         // prescale_select
    logic [15:0] cnt;        // counter
    logic        down;       // counting down in center mode
    logic [15:0] modv;       // modulo_value
    logic [7:0]  mod_hi_buf; // modulo high byte staged until low written
    logic        mod_pend;   // high modulo byte written, low byte pending
    logic [15:0] latch;      // coherency buffer
    logic        latched;    // buffer holds a pair
    logic        latch_hi;   // pair was taken by a high-byte read
    logic        clr_armed;  // flag read while set
    logic        pin_own;    // software claims shared pin for a channel
    logic        ap_valid;   // data phase pending
    logic        ap_write;   // data phase is write
    logic [7:0]  ap_addr;    // latched address
    logic [31:0] rdata;      // read data register
  } tpc_core_s;
  tpc_core_s st_reg;   // registered state
  tpc_core_s st_next;  // next state

  logic fix_rise;   // synchronized fixed clock edge
  logic ext_rise;   // synchronized external clock edge
  logic src_tick;   // selected source tick
  logic cnt_en;     // prescaled count enable
  logic at_mod;     // counter at terminal value
  logic ovf_evt;    // overflow event this cycle
  logic [15:0] top; // effective terminal count
  logic dbg_s1;     // debug sync first stage
  logic dbg_s2;     // debug sync second stage
  logic cnt_rst;    // counter byte written in this data phase

  tpc_sync_edge u_fix_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (fixed_clk),
    .rise_pls (fix_rise)
  );
  // external pin synchronizer; the pin must stay under a quarter of hclk
  tpc_sync_edge u_ext_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (ext_clk_pin),
    .rise_pls (ext_rise)
  );

  // debug level from another domain, two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_s1 <= 1'b0;
      dbg_s2 <= 1'b0;
    end else begin
      dbg_s1 <= debug_active;
      dbg_s2 <= dbg_s1;
    end
  end

  always_comb begin
    case (st_reg.clks)
      TPC_CLK_BUS: src_tick = 1'b1;
      TPC_CLK_FIX: src_tick = fix_rise;
      TPC_CLK_EXT: src_tick = ext_rise;
      default:     src_tick = 1'b0;
    endcase
  end

  // divider taps; placed after the source mux
  tpc_prescaler #(
    .PS_W (3)
  ) u_ps (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (src_tick),
    .freeze  (dbg_s2),
    .ps_sel  (st_reg.ps),
    .cnt_en  (cnt_en)
  );

  // modulo 0x0000 or 0xFFFF means full 16-bit range
  assign top    = (st_reg.modv == 16'h0000) ? 16'hFFFF : st_reg.modv;
  assign at_mod = (st_reg.cnt == top);
  // up mode overflow at wrap; center mode at first step down
  assign ovf_evt = cnt_en && !st_reg.mod_pend &&
                   (st_reg.center_aligned_pwm ? (at_mod && !st_reg.down) : at_mod);

  // bus decode, counter, flag and latch next-state
  always_comb begin
    logic        take;   // address phase accepted
    logic        wr;     // data-phase write
    logic        rd_sc;  // status read accepted this cycle
    logic [7:0]  wb;     // write byte
    take    = 1'b0;
    wr      = 1'b0;
    rd_sc   = 1'b0;
    wb      = hwdata[7:0];
    cnt_rst = 1'b0;
    st_next = st_reg;
    take    = hsel && hready && htrans[1];
    wr      = st_reg.ap_valid && st_reg.ap_write;

    // address phase capture
    st_next.ap_valid = take;
    st_next.ap_write = hwrite;
    st_next.ap_addr  = haddr;

    // write data phase
    if (wr) begin
      if (st_reg.ap_addr == TPC_OFS_SC) begin
        st_next.ovie = wb[TPC_SC_OVIE];
        st_next.center_aligned_pwm = wb[TPC_SC_CENTER_ALIGNED_PWM];
        st_next.clks = wb[TPC_SC_CLKHI:TPC_SC_CLKLO];
        st_next.ps   = wb[TPC_SC_PSHI:0];
        // zero write clears only after armed read, one has no effect
        if (!wb[TPC_SC_OVF] && st_reg.clr_armed) begin
          st_next.ovf = 1'b0;
        end
        st_next.clr_armed = 1'b0;
        st_next.latched = 1'b0;
      end else if (st_reg.ap_addr == TPC_OFS_CNTH || st_reg.ap_addr == TPC_OFS_CNTL) begin
        // any value resets counter; latch restart
        cnt_rst         = 1'b1;
        st_next.latched = 1'b0;
      end else if (st_reg.ap_addr == TPC_OFS_MODH) begin
        st_next.mod_hi_buf = wb;
        st_next.mod_pend   = 1'b1;
      end else if (st_reg.ap_addr == TPC_OFS_MODL) begin
        st_next.modv     = {st_reg.mod_hi_buf, wb};
        st_next.mod_pend = 1'b0;
      end else if (st_reg.ap_addr == TPC_OFS_CTRL) begin
        // claims the shared pin away from port controls
        st_next.pin_own = wb[0];
      end
    end

    // address-phase reads: data register filled for the data phase
    st_next.rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      if (haddr == TPC_OFS_SC) begin
        st_next.rdata[7:0] = {st_reg.ovf, st_reg.ovie, st_reg.center_aligned_pwm, st_reg.clks, st_reg.ps};
        rd_sc = 1'b1;
      end else if (haddr == TPC_OFS_CNTH || haddr == TPC_OFS_CNTL) begin
        // first byte read latches the pair; a read of the other byte, a status write or a counter write releases it
        if (st_reg.latched) begin
          st_next.rdata[7:0] = (haddr == TPC_OFS_CNTH) ? st_reg.latch[15:8] : st_reg.latch[7:0];
        end else begin
          st_next.rdata[7:0] = (haddr == TPC_OFS_CNTH) ? st_reg.cnt[15:8] : st_reg.cnt[7:0];
        end
        // latch state unchanged while debug is active
        if (!dbg_s2) begin
          if (!st_reg.latched) begin
            // take the pair and remember which byte took it
            st_next.latch    = st_reg.cnt;
            st_next.latched  = 1'b1;
            st_next.latch_hi = (haddr == TPC_OFS_CNTH);
          end else if (st_reg.latch_hi != (haddr == TPC_OFS_CNTH)) begin
            // re-reading the same byte keeps the pair, so either order stays coherent
            st_next.latched = 1'b0;
          end
        end
      end else if (haddr == TPC_OFS_MODH) begin
        st_next.rdata[7:0] = st_reg.modv[15:8];
      end else if (haddr == TPC_OFS_MODL) begin
        st_next.rdata[7:0] = st_reg.modv[7:0];
      end else if (haddr == TPC_OFS_CTRL) begin
        st_next.rdata[0] = st_reg.pin_own;
      end
    end
    // read of the set flag arms the clear
    if (rd_sc && st_reg.ovf) begin
      st_next.clr_armed = 1'b1;
    end

    // up counting or up/down in center mode; enable driven
    if (cnt_rst) begin
      st_next.cnt  = TPC_CNT_RESET;
      st_next.down = 1'b0;
    end else if (cnt_en) begin
      if (!st_reg.center_aligned_pwm) begin
        st_next.down = 1'b0;
        st_next.cnt  = at_mod ? 16'h0000 : st_reg.cnt + 16'h0001;
      end else if (!st_reg.down) begin
        st_next.down = at_mod;
        st_next.cnt  = at_mod ? st_reg.cnt - 16'h0001 : st_reg.cnt + 16'h0001;
      end else begin
        st_next.down = (st_reg.cnt != 16'h0001);
        st_next.cnt  = st_reg.cnt - 16'h0001;
      end
    end

    // new overflow disarms clear and wins over it
    if (ovf_evt) begin
      st_next.ovf       = 1'b1;
      st_next.clr_armed = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg      <= '0;
      st_reg.modv <= TPC_MOD_RESET;
      st_reg.cnt  <= TPC_CNT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign hrdata        = st_reg.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign count_value   = st_reg.cnt;
  assign center_pwm    = st_reg.center_aligned_pwm;
  assign count_tick    = cnt_en;
  assign overflow_pls  = ovf_evt;
  // request while flag and enable both set
  assign overflow_irq  = st_reg.ovf & st_reg.ovie;
  // external clock selection never hands the pin to a channel
  assign pin_timer_own = st_reg.pin_own && (st_reg.clks != TPC_CLK_EXT);

  // enabled overflow raises the request; a write may change the enable
  a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    (ovf_evt && st_reg.ovie && !(st_reg.ap_valid && st_reg.ap_write)) |=> overflow_irq)
    else $error("irq not raised by enabled overflow");
  // event keeps flag set next cycle
  a_ovf_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_evt |=> st_reg.ovf)
    else $error("overflow did not set flag");
  // up wrap to zero after modulo
  a_up_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_en && !st_reg.center_aligned_pwm && at_mod && !cnt_rst) |=> st_reg.cnt == 16'h0000)
    else $error("up count did not wrap");
  a_cnt_wr_rst: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.ap_valid && st_reg.ap_write &&
     (st_reg.ap_addr == TPC_OFS_CNTH || st_reg.ap_addr == TPC_OFS_CNTL)) |=>
      st_reg.cnt == 16'h0000)
    else $error("counter write did not reset");
  a_dbg_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
    (dbg_s2 && !(st_reg.ap_valid && st_reg.ap_write)) |=> $stable(st_reg.cnt))
    else $error("counter moved in debug");
  // debug freezes the coherency latch even across reads
  a_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (dbg_s2 && !(st_reg.ap_valid && st_reg.ap_write)) |=>
      ($stable(st_reg.latched) && $stable(st_reg.latch)))
    else $error("latch moved in debug");
  // status write restarts coherency when no read overlaps it
  a_latch_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.ap_valid && st_reg.ap_write && st_reg.ap_addr == TPC_OFS_SC &&
     !(hsel && hready && htrans[1] && !hwrite)) |=> !st_reg.latched)
    else $error("status write left latch held");
  // no clock source gives no count
  a_clk_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.clks == TPC_CLK_OFF) |-> !src_tick)
    else $error("tick with clock off");
  // divide by one passes every bus cycle
  a_ps_bypass: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.clks == TPC_CLK_BUS && st_reg.ps == 3'h0 && !dbg_s2) |-> cnt_en)
    else $error("divide by one skipped a cycle");
  // a pin tick only follows a rise seen two flops back
  a_sync_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.clks == TPC_CLK_EXT && src_tick) |->
      ($past(ext_clk_pin, 2) && !$past(ext_clk_pin, 3)))
    else $error("pin tick without synchronized edge");
  // flag never cleared without armed read
  a_clr_needs_rd: assert property (@(posedge hclk) disable iff (!hresetn)
    ($fell(st_reg.ovf)) |-> $past(st_reg.clr_armed))
    else $error("flag cleared without read");
  // unarmed flag stays set whatever is written
  a_flag_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.ovf && !st_reg.clr_armed) |=> st_reg.ovf)
    else $error("unarmed flag cleared");
  // writing one to the flag never clears it
  a_one_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.ovf && st_reg.ap_valid && st_reg.ap_write &&
     st_reg.ap_addr == TPC_OFS_SC && hwdata[TPC_SC_OVF]) |=> st_reg.ovf)
    else $error("flag cleared by a one");
  // center mode turns down at modulo
  a_center_aligned_pwm_down: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_en && st_reg.center_aligned_pwm && !st_reg.down && at_mod && !cnt_rst) |=> st_reg.down)
    else $error("center count did not turn");
  // center mode turns up again at the bottom
  a_center_bottom: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_en && st_reg.center_aligned_pwm && st_reg.down && st_reg.cnt == 16'h0001 && !cnt_rst) |=>
      (st_reg.cnt == 16'h0000 && !st_reg.down))
    else $error("center count did not turn up");
  // up mode steps by one; a counter write wins over the step
  a_up_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_en && !st_reg.center_aligned_pwm && !at_mod && !cnt_rst) |=>
      st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
    else $error("up count did not step");
endmodule // tpc_core

//--- tb/tpc_testbench.sv
// self-checking bench for the timer counter core over ahb-lite
`timescale 1ns/1ps
module testbench
  import tpc_pkg::*;
;
  logic        hclk;          // bus clock, 40 ns
  logic        hresetn;       // reset, active low
  logic        hsel;          // slave select
  logic [7:0]  haddr;         // byte address
  logic [1:0]  htrans;        // transfer type
  logic        hwrite;        // write strobe
  logic [2:0]  hsize;         // transfer size
  logic [31:0] hwdata;        // write data
  logic [31:0] hrdata;        // read data
  logic        hreadyout;     // slave ready, also bus hready
  logic        hresp;         // response
  logic        fixed_clk;     // fixed clock level
  logic        ext_clk_pin;   // external clock level
  logic        debug_active;  // debug freeze request
  logic [15:0] count_value;   // counter value
  logic        center_pwm;    // up-down select
  logic        count_tick;    // count enable
  logic        overflow_pls;  // overflow event
  logic        overflow_irq;  // interrupt request
  logic        pin_timer_own; // pin claim
  int          n_fail;        // mismatches
  int          n_compared;    // comparisons
  logic [31:0] q;             // last read data

  tpc_core i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fixed_clk(fixed_clk),
    .ext_clk_pin(ext_clk_pin), .debug_active(debug_active),
    .count_value(count_value), .center_pwm(center_pwm), .count_tick(count_tick),
    .overflow_pls(overflow_pls), .overflow_irq(overflow_irq),
    .pin_timer_own(pin_timer_own)
  );

  // free-running bus clock
  always #20 hclk = ~hclk;

  // verdict and end of run, also reached from any timeout
  task results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // single comparison point, four-state exact
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // a wait that ran out of its bound ends the run as a mismatch
  task timeout;
    n_fail++;
    $display("wrong value wait expected event seen timeout");
    results();
  endtask

  // next edge at which the slave is ready; bounded
  task wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) timeout();
      @(posedge hclk);
    end
  endtask

  // one whole-word transfer: address phase held until ready, then data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata; // taken at the closing edge, before it updates
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // read and compare in one go
  task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask

  // wait for an overflow (ovf) or a count enable; bounded
  task wait_ev(input bit ovf);
    int k;
    k = 0;
    @(posedge hclk);
    while ((ovf ? overflow_pls : count_tick) !== 1'b1) begin
      k++;
      if (k > 2000) timeout();
      @(posedge hclk);
    end
  endtask

  // slow clock pulses, period eight bus cycles; then let the synchronizer settle
  task pulses(input bit ext, input int n);
    repeat (n) begin
      if (ext) ext_clk_pin <= 1'b1;
      else fixed_clk <= 1'b1;
      repeat (4) @(posedge hclk);
      if (ext) ext_clk_pin <= 1'b0;
      else fixed_clk <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
  endtask

  task t_reset;
    rd("sc reset", TPC_OFS_SC, 32'h0);
    rd("cnth reset", TPC_OFS_CNTH, 32'h0);
    rd("cntl reset", TPC_OFS_CNTL, 32'h0);
    check("pin own reset", 32'(pin_timer_own), 32'h0);
    check("irq reset", 32'(overflow_irq), 32'h0);
    check("resp", 32'(hresp), 32'h0);
    // unmapped place: write ignored, reads zero
    wr(8'h18, 32'hFF);
    rd("unmapped", 8'h18, 32'h0);
    $display("done: reset values");
  endtask

  task t_prescale;
    int n;
    // bus clock with every prescale code, gap between enables
    for (int ps = 0; ps < 8; ps++) begin
      wr(TPC_OFS_SC, 32'h08 | 32'(ps));
      wait_ev(1'b0);
      n = 1;
      @(posedge hclk);
      while (count_tick !== 1'b1 && n < 300) begin
        n++;
        @(posedge hclk);
      end
      check("tick gap", 32'(n), 32'h1 << ps);
    end
    // fixed clock counts its own synchronized edges; any data resets the count
    wr(TPC_OFS_SC, 32'h10);
    wr(TPC_OFS_CNTH, 32'hFF);
    pulses(1'b0, 5);
    check("fixed count", 32'(count_value), 32'h5);
    // no clock selected: nothing counts
    wr(TPC_OFS_SC, 32'h00);
    pulses(1'b0, 3);
    pulses(1'b1, 3);
    check("off count", 32'(count_value), 32'h5);
    // the prescaler also divides the synchronized pin clock
    wr(TPC_OFS_SC, 32'h19);
    wr(TPC_OFS_CNTL, 32'h00);
    pulses(1'b1, 6);
    check("ext div2 count", 32'(count_value), 32'h3);
    $display("done: clock and prescale");
  endtask

  task t_latch;
    wr(TPC_OFS_SC, 32'h18);
    wr(TPC_OFS_CNTL, 32'h00);
    pulses(1'b1, 254);
    rd("cntl first", TPC_OFS_CNTL, 32'hFE);
    pulses(1'b1, 3);
    rd("cnth latched", TPC_OFS_CNTH, 32'h00);
    rd("cnth fresh", TPC_OFS_CNTH, 32'h01);
    rd("cntl paired", TPC_OFS_CNTL, 32'h01);
    // a status write restarts the latch
    rd("cntl latch", TPC_OFS_CNTL, 32'h01);
    pulses(1'b1, 1);
    wr(TPC_OFS_SC, 32'h18);
    rd("cntl restart", TPC_OFS_CNTL, 32'h02);
    rd("cnth restart", TPC_OFS_CNTH, 32'h01);
    // debug freezes counter and latch, reads included
    rd("cntl pre dbg", TPC_OFS_CNTL, 32'h02);
    debug_active <= 1'b1;
    repeat (4) @(posedge hclk);
    pulses(1'b1, 2);
    check("dbg count", 32'(count_value), 32'h0102);
    rd("cnth in dbg", TPC_OFS_CNTH, 32'h01);
    debug_active <= 1'b0;
    repeat (4) @(posedge hclk);
    pulses(1'b1, 1);
    check("post dbg count", 32'(count_value), 32'h0103);
    rd("cntl still held", TPC_OFS_CNTL, 32'h02);
    // same byte again: the pair waits for the other byte
    rd("cntl held again", TPC_OFS_CNTL, 32'h02);
    wr(TPC_OFS_CNTH, 32'hA5);
    @(posedge hclk);
    check("cnt write reset", 32'(count_value), 32'h0);
    $display("done: coherent reads");
  endtask

  task t_overflow;
    wr(TPC_OFS_SC, 32'h00);
    wr(TPC_OFS_MODH, 32'h00);
    wr(TPC_OFS_MODL, 32'h03);
    wr(TPC_OFS_CNTL, 32'h00);
    // slowest prescale so the clear steps fit between overflows
    wr(TPC_OFS_SC, 32'h0F);
    wait_ev(1'b1);
    check("ovf at mod", 32'(count_value), 32'h3);
    @(posedge hclk);
    check("wrap zero", 32'(count_value), 32'h0);
    check("up mode", 32'(center_pwm), 32'h0);
    rd("flag set", TPC_OFS_SC, 32'h8F);
    wr(TPC_OFS_SC, 32'h0F);
    rd("flag cleared", TPC_OFS_SC, 32'h0F);
    // write zero without a qualifying read
    wait_ev(1'b1);
    wr(TPC_OFS_SC, 32'h0F);
    rd("no read clear", TPC_OFS_SC, 32'h8F);
    wr(TPC_OFS_SC, 32'h8F);
    rd("one no effect", TPC_OFS_SC, 32'h8F);
    // overflow between read and write keeps the flag
    rd("arm", TPC_OFS_SC, 32'h8F);
    wait_ev(1'b1);
    wr(TPC_OFS_SC, 32'h4F);
    @(posedge hclk);
    check("irq on", 32'(overflow_irq), 32'h1);
    rd("flag kept", TPC_OFS_SC, 32'hCF);
    wr(TPC_OFS_SC, 32'h4F);
    @(posedge hclk);
    check("irq off", 32'(overflow_irq), 32'h0);
    // center mode: flag on the step down from modulo
    wr(TPC_OFS_SC, 32'h28);
    @(posedge hclk);
    check("center sel", 32'(center_pwm), 32'h1);
    wait_ev(1'b1);
    check("c ovf at mod", 32'(count_value), 32'h3);
    @(posedge hclk);
    check("count down", 32'(count_value), 32'h2);
    rd("c flag set", TPC_OFS_SC, 32'hA8);
    $display("done: overflow flag");
  endtask

  task t_pins;
    wr(TPC_OFS_CTRL, 32'h01);
    wr(TPC_OFS_SC, 32'h08);
    @(posedge hclk);
    check("pin claimed", 32'(pin_timer_own), 32'h1);
    // pin used as clock input: channel must leave it alone
    wr(TPC_OFS_SC, 32'h18);
    @(posedge hclk);
    check("pin as clock", 32'(pin_timer_own), 32'h0);
    wr(TPC_OFS_CTRL, 32'h00);
    wr(TPC_OFS_SC, 32'h08);
    @(posedge hclk);
    check("pin released", 32'(pin_timer_own), 32'h0);
    $display("done: pin ownership");
  endtask

  // main sequence: reset for twelve cycles, then each scenario
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fixed_clk = 1'b0;
    ext_clk_pin = 1'b0;
    debug_active = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_prescale();
    t_latch();
    t_overflow();
    t_pins();
    results();
  end
endmodule // testbench
